// ### verification/bus_master.sv
// bus_master: processor or dma writer on the register port
// assumes strobes launched just after a rising edge
`timescale 1ns/10ps
module bus_master (
    input  wire logic        clk,
    input  wire logic        ready,
    input  wire logic [31:0] rdata,
    output logic      [7:0]  addr,
    output logic      [31:0] wdata,
    output logic      [1:0]  wsize,
    output logic             wr,
    output logic             rd
);
    initial begin
        addr = 8'hFF;
        wdata = 32'h00000000;
        wsize = 2'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // writes chain with no gap and no handshake
    task put(input logic [7:0] a, input logic [31:0] d,
             input logic [1:0] z, output logic t);
        addr <= a;
        wdata <= d;
        wsize <= z;
        wr <= 1'b1;
        rd <= 1'b0;
        #1 t = ready;
        @(posedge clk);
    endtask : put
    task get(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1 v = rdata;
    endtask : get
    // released addr and wdata lines show no stale value; wsize keeps its value
    task idle;
        wr <= 1'b0;
        rd <= 1'b0;
        wdata <= ~wdata;
        addr <= ~addr;
        @(posedge clk);
    endtask : idle
endmodule : bus_master

// ### verification/crc_engine_programmable_test.sv
// crc_engine_programmable_test: self-checking bench for crc_engine
// assumes bus_master as writer and crc_engine_props bound below
`timescale 1ns/10ps
module crc_engine_programmable_test;
    typedef struct {
        logic [5:0]  m;
        logic [31:0] s;
        logic [31:0] d;
        logic [1:0]  z;
    } row_s;
    logic        clk;
    logic        rst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [1:0]  wsize;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        ready;
    logic        sum_valid;
    logic [31:0] v;
    logic [31:0] e;
    logic        t;
    int          bad_count = 0;
    int          n_checks = 0;
    int          n;
    row_s        r;
    row_s rows [10] = '{'{6'h00, 32'h0000FFFF, 32'h00000031, 2'h0},
        '{6'h01, 32'h00000000, 32'h00001234, 2'h1},
        '{6'h02, 32'hFFFFFFFF, 32'hDEADBEEF, 2'h2},
        '{6'h06, 32'hFFFFFFFF, 32'h12345678, 2'h2},
        '{6'h3E, 32'hFFFFFFFF, 32'h000000A5, 2'h0},
        '{6'h0D, 32'h00000000, 32'h0000ABCD, 2'h1},
        '{6'h10, 32'h00001D0F, 32'h0000005A, 2'h3},
        '{6'h03, 32'hFFFFFFFF, 32'h000000FF, 2'h1},
        '{6'h22, 32'h00000000, 32'h00000001, 2'h2},
        '{6'h31, 32'h0000FFFF, 32'h0000BEEF, 2'h1}};
    crc_engine uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wsize(wsize), .wr(wr), .rd(rd), .rdata(rdata), .ready(ready),
        .sum_valid(sum_valid));
    bus_master mst (.clk(clk), .ready(ready), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wsize(wsize), .wr(wr), .rd(rd));
    function automatic logic [31:0] fold(row_s q, logic [31:0] s);
        logic [31:0] g;
        logic [7:0]  b;
        logic        w;
        w = q.m[1:0] == 2'h2;
        g = w ? crc_pkg::GEN_CRC32 : q.m[1:0] == 2'h1 ?
            crc_pkg::GEN_CRC16 : crc_pkg::GEN_CCITT;
        if (!w) s = s & crc_pkg::MASK16;
        for (int k = (q.z == 2'h2 ? 3 : q.z == 2'h1 ? 1 : 0); k >= 0; k--)
        begin
            b = q.d[8*k +: 8];
            if (q.m[2]) b = {<<{b}};
            if (q.m[3]) b = ~b;
            for (int i = 7; i >= 0; i--)
                s = ((w ? s[31] : s[15]) ^ b[i]) ? (s << 1) ^ g : s << 1;
        end
        return w ? s : s & crc_pkg::MASK16;
    endfunction : fold
    function automatic logic [31:0] view(logic [5:0] m, logic [31:0] s);
        logic [31:0] r;
        logic [15:0] h;
        logic [31:0] k;
        r = {<<{s}};
        h = {<<{s[15:0]}};
        k = m[1:0] == 2'h2 ? crc_pkg::MASK32 : crc_pkg::MASK16;
        if (m[4]) s = m[1:0] == 2'h2 ? r : {16'h0000, h};
        return m[5] ? s ^ k : s;
    endfunction : view
    task cmp32(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : cmp32
    task cmp1(input logic g, input logic x);
        cmp32({31'h0, g}, {31'h0, x});
    endtask : cmp1
    task final_report;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task wait_valid;
        int i;
        #1;
        for (i = 0; i < 100 && sum_valid !== 1'b1; i++) @(posedge clk) #1;
        if (sum_valid !== 1'b1) begin
            bad_count++;
            final_report();
        end
    endtask : wait_valid
    task setup(input logic [5:0] m, input logic [31:0] s);
        mst.put(crc_pkg::OFF_MODE, {26'h0, m}, 2'h0, t);
        mst.put(crc_pkg::OFF_SEED, s, 2'h0, t);
    endtask : setup
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[j]) begin
            setup(rows[j].m, rows[j].s);
            mst.put(crc_pkg::OFF_SUM, rows[j].d, rows[j].z, t);
            mst.idle();
            wait_valid();
            mst.get(crc_pkg::OFF_SUM, v);
            e = view(rows[j].m, fold(rows[j], rows[j].s));
            cmp32(v, e);
            mst.get(crc_pkg::OFF_MODE, v);
            cmp32(v, {26'h0, rows[j].m});
        end
        $display("table rows done");
        setup(6'h02, 32'hFFFFFFFF);
        e = 32'hFFFFFFFF;
        n = 0;
        for (int j = 0; j < 24; j++) begin
            r = '{6'h02, 32'h0, 32'h01010101 * j, crc_pkg::SIZE_32};
            mst.put(crc_pkg::OFF_SUM, r.d, r.z, t);
            if (t) e = fold(r, e);
            if (t) n++;
        end
        mst.idle();
        #1 cmp1(sum_valid, 1'b0);
        cmp1(n < 24, 1'b1);
        wait_valid();
        mst.get(crc_pkg::OFF_SUM, v);
        cmp32(v, e);
        $display("fill test done");
        setup(6'h00, 32'h0000FFFF);
        e = 32'h0000FFFF;
        for (int j = 0; j < 4; j++) begin
            r = '{6'h00, 32'h0, 32'hD4E5F6A1 >> (8 * j), 2'(j % 3)};
            mst.put(crc_pkg::OFF_SUM, r.d, r.z, t);
            e = fold(r, e);
        end
        mst.idle();
        wait_valid();
        mst.get(crc_pkg::OFF_SUM, v);
        cmp32(v, e);
        mst.get(crc_pkg::OFF_SUM, v);
        cmp32(v, e);
        mst.get(8'h0C, v);
        cmp32(v, 32'h00000000);
        $display("mixed test done");
        mst.put(crc_pkg::OFF_MODE, 32'h0000003F, 2'h0, t);
        mst.put(crc_pkg::OFF_SUM, 32'h89ABCDEF, crc_pkg::SIZE_32, t);
        rst <= 1'b1;
        mst.idle();
        mst.idle();
        rst <= 1'b0;
        #1 cmp1(ready, 1'b1);
        cmp1(sum_valid, 1'b1);
        mst.get(crc_pkg::OFF_SUM, v);
        cmp32(v, crc_pkg::SEED_RESET);
        mst.get(crc_pkg::OFF_MODE, v);
        cmp32(v, {26'h0, crc_pkg::MODE_RESET});
        mst.get(crc_pkg::OFF_SEED, v);
        cmp32(v, crc_pkg::SEED_RESET);
        $display("reset test done");
        final_report();
    end
endmodule : crc_engine_programmable_test
bind crc_engine crc_engine_props u_props (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wsize(wsize), .wr(wr), .rd(rd),
    .rdata(rdata), .ready(ready), .sum_valid(sum_valid));

// ### verification/crc_engine_props.sv
// crc_engine_props: timing checks on the checksum engine ports
// assumes binding onto crc_engine, one clock, rst synchronous
`timescale 1ns/10ps
module crc_engine_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic [1:0]  wsize,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        ready,
    input wire logic        sum_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // lone data write into an idle, empty engine
    sequence s_wd(logic [1:0] z);
        wr && addr == crc_pkg::OFF_SUM && wsize == z && sum_valid;
    endsequence
    sequence s_sumrd;
        rd && !wr && addr == crc_pkg::OFF_SUM;
    endsequence
    property p_w8;
        s_wd(crc_pkg::SIZE_8) ##1 !wr [*3]
            |-> sum_valid && !$past(sum_valid) && !$past(sum_valid, 2);
    endproperty
    property p_w16;
        s_wd(crc_pkg::SIZE_16) ##1 !wr [*4]
            |-> sum_valid && !$past(sum_valid) && !$past(sum_valid, 2);
    endproperty
    property p_w32;
        s_wd(crc_pkg::SIZE_32) ##1 !wr [*6]
            |-> sum_valid && !$past(sum_valid) && !$past(sum_valid, 2);
    endproperty
    property p_rd0;
        !rd |=> rdata == 32'h00000000;
    endproperty
    property p_unm;
        rd && addr > crc_pkg::OFF_SUM |=> rdata == 32'h00000000;
    endproperty
    property p_hold;
        (s_sumrd and sum_valid) ##1 s_sumrd |=> rdata == $past(rdata);
    endproperty
    property p_fell;
        $fell(sum_valid) |-> $past(wr) && $past(addr) == crc_pkg::OFF_SUM;
    endproperty
    property p_rdy;
        $fell(ready) |-> $past(wr) && $past(addr) == crc_pkg::OFF_SUM;
    endproperty
    property p_sv;
        sum_valid |-> ready;
    endproperty
    a_w8: assert property (p_w8) else $error("byte fold time");
    a_w16: assert property (p_w16) else $error("half fold time");
    a_w32: assert property (p_w32) else $error("word fold time");
    a_rd0: assert property (p_rd0) else $error("rdata not idle");
    a_unm: assert property (p_unm) else $error("unmapped read");
    a_hold: assert property (p_hold) else $error("sum moved");
    a_fell: assert property (p_fell) else $error("valid lost");
    a_rdy: assert property (p_rdy) else $error("ready lost");
    a_sv: assert property (p_sv) else $error("idle not ready");
endmodule : crc_engine_props

// ### verilog/crc_engine.sv
// crc_engine: programmable checksum generator behind a register port
// assumes a single-cycle register master that watches ready and sum_valid
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module crc_engine (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic [1:0]  wsize,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             ready,
    output logic             sum_valid
);
    fifo_if #(.WIDTH(crc_pkg::ENTRY_W)) buf_if ();

    crc_pkg::engine_state_e state;
    crc_pkg::engine_state_e next_state;
    logic [5:0]   mode;
    logic [5:0]   next_mode;
    logic [31:0]  seed;
    logic [31:0]  next_seed;
    logic [31:0]  crc;
    logic [31:0]  next_crc;
    logic [31:0]  word;
    logic [31:0]  next_word;
    logic [1:0]   steps;
    logic [1:0]   next_steps;
    logic [31:0]  next_rdata;

    logic         data_wr;
    logic         wide16;
    logic [31:0]  gen;
    logic [31:0]  width_mask;
    logic [31:0]  sum_view;
    logic [7:0]   in_byte;
    logic         load;
    logic [1:0]   pop_size;
    logic [31:0]  pop_word;
    logic [31:0]  stage [9];
    logic [31:0]  fold_out;
    logic [7:0]   byte_rev;
    logic [31:0]  sum_rev;
    logic [15:0]  sum_rev16;

    word_fifo #(
        .WIDTH (crc_pkg::ENTRY_W),
        .DEPTH (crc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk  (clk),
        .rst  (rst),
        .port (buf_if)
    );

    // writes beyond a full buffer are dropped; master watches ready
    assign data_wr           = wr && (addr == crc_pkg::OFF_SUM);
    assign buf_if.push_valid = data_wr;
    assign buf_if.push_data  = {wsize, wdata};
    assign ready             = buf_if.push_ready;
    assign pop_size  = buf_if.pop_data[crc_pkg::ENTRY_W-1:crc_pkg::DATA_W];
    assign pop_word  = buf_if.pop_data[crc_pkg::DATA_W-1:0];

    // sum is complete only with nothing buffered or in flight
    assign sum_valid = (state == crc_pkg::ST_IDLE) &&
                       !buf_if.pop_valid;

    always_comb begin
        case (mode[crc_pkg::POLY_LSB +: crc_pkg::POLY_W])
            crc_pkg::POLY_CRC16: gen = crc_pkg::GEN_CRC16;
            crc_pkg::POLY_CRC32: gen = crc_pkg::GEN_CRC32;
            default:             gen = crc_pkg::GEN_CCITT;
        endcase
    end

    assign wide16 = (mode[crc_pkg::POLY_LSB +: crc_pkg::POLY_W]
                     != crc_pkg::POLY_CRC32);
    assign width_mask = wide16 ? crc_pkg::MASK16 : crc_pkg::MASK32;

    // one byte step as eight shift stages, msb of the byte first
    assign stage[0] = crc;

    genvar b;
    generate
        for (b = 0; b < 8; b = b + 1) begin : g_step
            logic        fb;
            logic [31:0] shifted;
            assign fb         = (wide16 ? stage[b][15] : stage[b][31])
                                ^ in_byte[7-b];
            assign shifted    = {stage[b][30:0], 1'b0};
            assign stage[b+1] = fb ? (shifted ^ gen) : shifted;
        end
    endgenerate

    // 16-bit modes keep the upper half of the sum clear
    assign fold_out = wide16 ? (stage[8] & crc_pkg::MASK16) : stage[8];

    // bit mirrors for the input byte and for both sum widths
    generate
        for (b = 0; b < 8; b = b + 1) begin : g_rev_byte
            assign byte_rev[b] = word[31-b];
        end
        for (b = 0; b < 16; b = b + 1) begin : g_rev_half
            assign sum_rev16[b] = crc[15-b];
        end
        for (b = 0; b < 32; b = b + 1) begin : g_rev_word
            assign sum_rev[b] = crc[31-b];
        end
    endgenerate

    // input byte: top byte of the staged word, then options
    always_comb begin
        in_byte = word[31:24];
        if (mode[crc_pkg::BIT_REV_WR]) begin
            in_byte = byte_rev;
        end
        if (mode[crc_pkg::CMPL_WR]) begin
            in_byte = ~in_byte;
        end
    end

    // read view of the sum with its own options
    always_comb begin
        sum_view = crc & width_mask;
        if (mode[crc_pkg::BIT_REV_SUM]) begin
            sum_view = wide16 ? {16'h0000, sum_rev16} : sum_rev;
        end
        if (mode[crc_pkg::CMPL_SUM]) begin
            sum_view = sum_view ^ width_mask;
        end
    end

    // register file
    always_comb begin
        next_mode  = mode;
        next_seed  = seed;
        next_rdata = '0;
        if (wr && addr == crc_pkg::OFF_MODE) begin
            next_mode = wdata[crc_pkg::MODE_W-1:0];
        end
        if (wr && addr == crc_pkg::OFF_SEED) begin
            next_seed = wdata;
        end
        if (rd) begin
            case (addr)
                crc_pkg::OFF_MODE: next_rdata = {26'h0, mode};
                crc_pkg::OFF_SEED: next_rdata = seed;
                crc_pkg::OFF_SUM:  next_rdata = sum_view;
                default:           next_rdata = '0;
            endcase
        end
    end

    // byte engine: one byte per cycle while running
    always_comb begin
        next_state = state;
        next_crc   = crc;
        next_word  = word;
        next_steps = steps;
        load       = 1'b0;
        case (state)
            crc_pkg::ST_IDLE: begin
                load = buf_if.pop_valid;
            end
            crc_pkg::ST_RUN: begin
                next_crc  = fold_out;
                next_word = {word[23:0], 8'h00};
                if (steps != 2'h0) begin
                    next_steps = steps - 2'h1;
                end else begin
                    load = buf_if.pop_valid;
                    if (!buf_if.pop_valid) begin
                        next_state = crc_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = crc_pkg::ST_IDLE;
            end
        endcase
        if (load) begin
            next_state = crc_pkg::ST_RUN;
            case (pop_size)
                crc_pkg::SIZE_16: begin
                    next_word  = {pop_word[15:0], 16'h0000};
                    next_steps = crc_pkg::STEPS_16;
                end
                crc_pkg::SIZE_32: begin
                    next_word  = pop_word;
                    next_steps = crc_pkg::STEPS_32;
                end
                default: begin
                    next_word  = {pop_word[7:0], 24'h000000};
                    next_steps = crc_pkg::STEPS_8;
                end
            endcase
        end
        // seed write restarts the sum; buffered words fold on top
        if (wr && addr == crc_pkg::OFF_SEED) begin
            next_crc = wdata & width_mask;
        end
    end

    assign buf_if.pop_ready = load;

    // register file and read data
    always_ff @(posedge clk) begin
        if (rst) begin
            mode  <= crc_pkg::MODE_RESET;
            seed  <= crc_pkg::SEED_RESET;
            rdata <= '0;
        end else begin
            mode  <= next_mode;
            seed  <= next_seed;
            rdata <= next_rdata;
        end
    end

    // byte engine; the sum restarts from the reset seed
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= crc_pkg::ST_IDLE;
            crc   <= crc_pkg::SEED_RESET;
            word  <= '0;
            steps <= '0;
        end else begin
            state <= next_state;
            crc   <= next_crc;
            word  <= next_word;
            steps <= next_steps;
        end
    end
endmodule : crc_engine

// ### verilog/crc_pkg.sv
// crc_pkg: register map, mode fields, polynomials and sizes
// assumes a 32-bit register port with byte addresses
package crc_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          SIZE_W        = 2;
    localparam int          ENTRY_W       = DATA_W + SIZE_W;

    localparam logic [7:0]  OFF_MODE      = 8'h00;
    localparam logic [7:0]  OFF_SEED      = 8'h04;
    localparam logic [7:0]  OFF_SUM       = 8'h08;

    localparam int          POLY_LSB      = 0;
    localparam int          POLY_W        = 2;
    localparam int          BIT_REV_WR    = 2;
    localparam int          CMPL_WR       = 3;
    localparam int          BIT_REV_SUM   = 4;
    localparam int          CMPL_SUM      = 5;
    localparam int          MODE_W        = 6;

    localparam logic [5:0]  MODE_RESET    = 6'h00;
    localparam logic [31:0] SEED_RESET    = 32'h00000000;

    localparam logic [1:0]  POLY_CCITT    = 2'h0;
    localparam logic [1:0]  POLY_CRC16    = 2'h1;
    localparam logic [1:0]  POLY_CRC32    = 2'h2;
    localparam logic [31:0] GEN_CCITT     = 32'h00001021;
    localparam logic [31:0] GEN_CRC16     = 32'h00008005;
    localparam logic [31:0] GEN_CRC32     = 32'h04C11DB7;
    localparam logic [31:0] MASK16        = 32'h0000FFFF;
    localparam logic [31:0] MASK32        = 32'hFFFFFFFF;

    localparam logic [1:0]  SIZE_8        = 2'h0;
    localparam logic [1:0]  SIZE_16       = 2'h1;
    localparam logic [1:0]  SIZE_32       = 2'h2;
    localparam logic [1:0]  STEPS_8       = 2'h0;
    localparam logic [1:0]  STEPS_16      = 2'h1;
    localparam logic [1:0]  STEPS_32      = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } engine_state_e;
endpackage : crc_pkg

// ### verilog/fifo_if.sv
// fifo_if: push and pop handshakes around the word buffer
// assumes one clock shared by both sides
`timescale 1ns/10ps
interface fifo_if #(parameter int WIDTH = 8);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport fill  (output push_valid, push_data, input push_ready);
    modport drain (input pop_valid, pop_data, output pop_ready);
    modport fifo  (input push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data);
endinterface : fifo_if

// ### verilog/word_fifo.sv
// word_fifo: synchronous first-in first-out buffer
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    fifo_if.fifo     port
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W:0]   wr_ptr;
    logic [PTR_W:0]   rd_ptr;
    logic [PTR_W:0]   next_wr_ptr;
    logic [PTR_W:0]   next_rd_ptr;
    logic             full;
    logic             empty;
    logic             do_push;
    logic             do_pop;

    assign empty = (wr_ptr == rd_ptr);
    assign full  = (wr_ptr[PTR_W] != rd_ptr[PTR_W]) &&
                   (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]);
    assign port.push_ready = !full;
    assign port.pop_valid  = !empty;
    assign port.pop_data   = mem[rd_ptr[PTR_W-1:0]];
    assign do_push = port.push_valid && !full;
    assign do_pop  = port.pop_ready && !empty;

    always_comb begin
        next_wr_ptr = wr_ptr + (PTR_W+1)'(do_push);
        next_rd_ptr = rd_ptr + (PTR_W+1)'(do_pop);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr[PTR_W-1:0]] <= port.push_data;
        end
    end
endmodule : word_fifo
